// >>> rtl/i2cms_pkg.sv
// Constants and types shared by the two-wire master sequencer.
package i2cms_pkg;

  // Header pattern that marks the first byte of a 10-bit address.
  localparam logic [4:0] HDR10_PATTERN = 5'h1e;
  localparam int HDR10_MSB = 7;
  localparam int HDR10_LSB = 3;
  // Position of the direction bit inside an address byte.
  localparam int DIR_BIT = 0;
  // Packet error check polynomial x^8 + x^2 + x + 1.
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;
  // Bits per byte on the wire and the index of the acknowledge slot.
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Quarter-bit phases of the link engine.
  localparam logic [1:0] QTR_DATA = 2'h0;
  localparam logic [1:0] QTR_RISE = 2'h1;
  localparam logic [1:0] QTR_SAMPLE = 2'h2;
  localparam logic [1:0] QTR_FALL = 2'h3;

  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } i2cms_cmd_t;

  typedef enum logic [3:0] {
    C_SLAVE,
    C_START,
    C_ADDR_REQ,
    C_ADDR_SEND,
    C_HDR_WAIT,
    C_ADDR_DONE,
    C_RX,
    C_RX_WAIT,
    C_HOLD,
    C_STOP
  } i2cms_cstate_t;

  typedef enum logic [1:0] {
    L_IDLE,
    L_START,
    L_BIT,
    L_STOP
  } i2cms_lstate_t;

endpackage

// >>> rtl/i2cms_top.sv
// Master sequencer of the two-wire serial interface, with its bit engine on the link clock.
// Summary of operation
// - Stop set while byte done frees lines.
// - Comes out of reset as a slave.
// - Start on idle bus enters master mode.
// - Start sent raises event and start flags.
// - Clock held low until status read, data write.
// - Address shifted out; 7-bit uses one byte.
// - 10-bit header event, then second address byte.
// - Address done event, waits status read, control write.
// - Received byte stored, acknowledge if enabled.
// - Each received byte sets event and byte done.
// - Clock held low until status read, data read.
// - After stop returns to slave, clears master.
// - Packet error check CRC-8 kept over bus bytes.
`timescale 1ns/1ps
`default_nettype none

module i2cms_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic INTERFACE_ENABLE,
  input wire logic START_REQ,
  input wire logic STOP_REQ,
  input wire logic ACK_ENABLE,
  input wire logic INTERRUPT_ENABLE,
  input wire logic SR1_READ,
  input wire logic DR_READ,
  input wire logic DR_WRITE,
  input wire logic CR_WRITE,
  input wire logic [7:0] DR_WDATA,
  output logic [7:0] DR_RDATA,
  output logic EVENT_FLAG,
  output logic START_SENT_FLAG,
  output logic BYTE_DONE_FLAG,
  output logic MASTER_SELECT_FLAG,
  output logic BUS_BUSY_FLAG,
  output logic ADDR10_FLAG,
  output logic ACK_FAIL_FLAG,
  output logic [7:0] PEC_VALUE,
  output logic IRQ,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  // State of the processor-side sequencer on REF_CLK.
  typedef struct packed {
    i2cms_pkg::i2cms_cstate_t st;
    i2cms_pkg::i2cms_cmd_t cmd;
    logic [7:0] tx;
    logic ack_en;
    logic req_tgl;
    logic done_s0;
    logic done_s1;
    logic done_seen;
    logic scl_s0;
    logic scl_s1;
    logic scl_s2;
    logic sda_s0;
    logic sda_s1;
    logic sda_s2;
    logic busy;
    logic start_prev;
    logic start_pend;
    logic stop_pend;
    logic sr1_seen;
    logic event_flag;
    logic sb;
    logic byte_done_flag;
    logic msl;
    logic addr10;
    logic second_pend;
    logic dir_rx;
    logic ack_fail;
    logic [7:0] dr;
    logic [7:0] pec;
  } i2cms_core_t;

  // State of the bit engine on LINK_CLK.
  typedef struct packed {
    logic rs0;
    logic rs1;
    logic rq0;
    logic rq1;
    logic seen;
    logic scl_s0;
    logic scl_s1;
    logic sda_s0;
    logic sda_s1;
    i2cms_pkg::i2cms_lstate_t st;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] rx;
    logic ackd;
    logic done_tgl;
    logic scl_lo;
    logic sda_lo;
  } i2cms_link_t;

  i2cms_core_t q;
  i2cms_core_t n;
  i2cms_link_t lq;
  i2cms_link_t ln;
  logic done_evt;

  // Bytewise CRC-8 update, used for both address and data bytes.
  function automatic logic [7:0] i2cms_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ i2cms_pkg::PEC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Hands one command to the link engine; cmd and tx stay stable until it answers.
  function automatic i2cms_core_t i2cms_issue(input i2cms_core_t s, input i2cms_pkg::i2cms_cmd_t c,
                                              input logic [7:0] d, input logic a);
    i2cms_core_t r;
    r = s;
    r.cmd = c;
    r.tx = d;
    r.ack_en = a;
    r.req_tgl = ~s.req_tgl;
    return r;
  endfunction

  // One toggle from the link marks the end of the command in flight.
  assign done_evt = q.done_s1 != q.done_seen;

  // Sequencer next state: synchronisers, bus watch, flags and the transfer sequence.
  always_comb begin
    n = q;
    n.done_s0 = lq.done_tgl;
    n.done_s1 = q.done_s0;
    n.done_seen = q.done_s1;
    n.scl_s0 = SCL_I;
    n.scl_s1 = q.scl_s0;
    n.scl_s2 = q.scl_s1;
    n.sda_s0 = SDA_I;
    n.sda_s1 = q.sda_s0;
    n.sda_s2 = q.sda_s1;
    // Busy follows start and stop conditions seen on the wire by anyone.
    if (q.scl_s1 && q.scl_s2 && !q.sda_s1 && q.sda_s2) begin
      n.busy = 1'b1;
    end
    if (q.scl_s1 && q.scl_s2 && q.sda_s1 && !q.sda_s2) begin
      n.busy = 1'b0;
    end
    // A start request is remembered on its rising edge so a held bit does not restart.
    n.start_prev = START_REQ;
    if (START_REQ && !q.start_prev) begin
      n.start_pend = 1'b1;
    end
    // Stop toggled while a byte waits is kept until the byte is handed over.
    if (STOP_REQ && q.byte_done_flag) begin
      n.stop_pend = 1'b1;
    end
    if (SR1_READ) begin
      n.sr1_seen = 1'b1;
    end
    case (q.st)
      i2cms_pkg::C_SLAVE: begin
        n.msl = 1'b0;
        if (!INTERFACE_ENABLE) begin
          n.start_pend = 1'b0;
        end else if (q.start_pend && !q.busy) begin
          n = i2cms_issue(n, i2cms_pkg::CMD_START, 8'h00, 1'b0);
          n.msl = 1'b1;
          n.start_pend = 1'b0;
          n.ack_fail = 1'b0;
          n.st = i2cms_pkg::C_START;
        end
      end
      i2cms_pkg::C_START: begin
        if (done_evt) begin
          n.event_flag = 1'b1;
          n.sb = 1'b1;
          n.sr1_seen = 1'b0;
          n.pec = i2cms_pkg::PEC_INIT;
          n.st = i2cms_pkg::C_ADDR_REQ;
        end
      end
      i2cms_pkg::C_ADDR_REQ: begin
        // Clock stays low in the engine until the address write arrives.
        if (DR_WRITE && q.sr1_seen) begin
          n.event_flag = 1'b0;
          n.sb = 1'b0;
          n.dir_rx = DR_WDATA[i2cms_pkg::DIR_BIT];
          n.addr10 = DR_WDATA[i2cms_pkg::HDR10_MSB:i2cms_pkg::HDR10_LSB]
                     == i2cms_pkg::HDR10_PATTERN;
          // A header with the read bit set follows a repeated start and stands alone.
          n.second_pend = n.addr10 && !n.dir_rx;
          n.pec = i2cms_crc8(q.pec, DR_WDATA);
          n = i2cms_issue(n, i2cms_pkg::CMD_WRITE, DR_WDATA, 1'b0);
          n.st = i2cms_pkg::C_ADDR_SEND;
        end
      end
      i2cms_pkg::C_ADDR_SEND: begin
        if (done_evt) begin
          if (!lq.ackd) begin
            n.ack_fail = 1'b1;
          end
          n.event_flag = 1'b1;
          n.sr1_seen = 1'b0;
          n.st = q.second_pend ? i2cms_pkg::C_HDR_WAIT : i2cms_pkg::C_ADDR_DONE;
        end
      end
      i2cms_pkg::C_HDR_WAIT: begin
        if (DR_WRITE && q.sr1_seen) begin
          n.event_flag = 1'b0;
          n.second_pend = 1'b0;
          n.pec = i2cms_crc8(q.pec, DR_WDATA);
          n = i2cms_issue(n, i2cms_pkg::CMD_WRITE, DR_WDATA, 1'b0);
          n.st = i2cms_pkg::C_ADDR_SEND;
        end
      end
      i2cms_pkg::C_ADDR_DONE: begin
        if (CR_WRITE && q.sr1_seen) begin
          n.event_flag = 1'b0;
          if (q.dir_rx) begin
            n = i2cms_issue(n, i2cms_pkg::CMD_READ, 8'h00, ACK_ENABLE);
            n.st = i2cms_pkg::C_RX;
          end else begin
            n.st = i2cms_pkg::C_HOLD;
          end
        end
      end
      i2cms_pkg::C_RX: begin
        if (done_evt) begin
          n.dr = lq.rx;
          n.pec = i2cms_crc8(q.pec, lq.rx);
          n.event_flag = 1'b1;
          n.byte_done_flag = 1'b1;
          n.sr1_seen = 1'b0;
          n.st = i2cms_pkg::C_RX_WAIT;
        end
      end
      i2cms_pkg::C_RX_WAIT: begin
        // The acknowledge choice for the next byte is taken at this data read.
        if (DR_READ && q.sr1_seen) begin
          n.event_flag = 1'b0;
          n.byte_done_flag = 1'b0;
          if (STOP_REQ || q.stop_pend) begin
            n.stop_pend = 1'b0;
            n = i2cms_issue(n, i2cms_pkg::CMD_STOP, 8'h00, 1'b0);
            n.st = i2cms_pkg::C_STOP;
          end else begin
            n = i2cms_issue(n, i2cms_pkg::CMD_READ, 8'h00, ACK_ENABLE);
            n.st = i2cms_pkg::C_RX;
          end
        end
      end
      i2cms_pkg::C_HOLD: begin
        // Transmit direction is not served here: only stop or repeated start leave.
        if (STOP_REQ || q.stop_pend) begin
          n.stop_pend = 1'b0;
          n = i2cms_issue(n, i2cms_pkg::CMD_STOP, 8'h00, 1'b0);
          n.st = i2cms_pkg::C_STOP;
        end else if (q.start_pend) begin
          n.start_pend = 1'b0;
          n = i2cms_issue(n, i2cms_pkg::CMD_START, 8'h00, 1'b0);
          n.st = i2cms_pkg::C_START;
        end
      end
      i2cms_pkg::C_STOP: begin
        if (done_evt) begin
          n.msl = 1'b0;
          n.st = i2cms_pkg::C_SLAVE;
        end
      end
      default: begin
        n.st = i2cms_pkg::C_SLAVE;
      end
    endcase
  end

  // Sequencer register.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Bit engine next state; each bit takes at least six link clocks, as the sample phase waits on the synchronised clock, and waits out slave stretching.
  always_comb begin
    ln = lq;
    ln.rs0 = RST;
    ln.rs1 = lq.rs0;
    ln.rq0 = q.req_tgl;
    ln.rq1 = lq.rq0;
    ln.scl_s0 = SCL_I;
    ln.scl_s1 = lq.scl_s0;
    ln.sda_s0 = SDA_I;
    ln.sda_s1 = lq.sda_s0;
    case (lq.st)
      i2cms_pkg::L_IDLE: begin
        // Idle after a byte keeps SCL low, which is what stretches the bus.
        if (lq.rq1 != lq.seen) begin
          ln.seen = lq.rq1;
          ln.qtr = i2cms_pkg::QTR_DATA;
          ln.bitn = 4'h0;
          ln.sh = q.tx;
          case (q.cmd)
            i2cms_pkg::CMD_START: ln.st = i2cms_pkg::L_START;
            i2cms_pkg::CMD_STOP: ln.st = i2cms_pkg::L_STOP;
            default: ln.st = i2cms_pkg::L_BIT;
          endcase
        end
      end
      i2cms_pkg::L_START: begin
        ln.qtr = lq.qtr + 2'h1;
        case (lq.qtr)
          i2cms_pkg::QTR_DATA: ln.sda_lo = 1'b0;
          i2cms_pkg::QTR_RISE: ln.scl_lo = 1'b0;
          i2cms_pkg::QTR_SAMPLE: begin
            if (lq.scl_s1) begin
              ln.sda_lo = 1'b1;
            end else begin
              ln.qtr = lq.qtr;
            end
          end
          default: begin
            ln.scl_lo = 1'b1;
            ln.done_tgl = ~lq.done_tgl;
            ln.st = i2cms_pkg::L_IDLE;
          end
        endcase
      end
      i2cms_pkg::L_STOP: begin
        ln.qtr = lq.qtr + 2'h1;
        case (lq.qtr)
          i2cms_pkg::QTR_DATA: begin
            ln.scl_lo = 1'b1;
            ln.sda_lo = 1'b1;
          end
          i2cms_pkg::QTR_RISE: ln.scl_lo = 1'b0;
          default: begin
            if (lq.scl_s1) begin
              ln.sda_lo = 1'b0;
              ln.done_tgl = ~lq.done_tgl;
              ln.st = i2cms_pkg::L_IDLE;
            end else begin
              ln.qtr = lq.qtr;
            end
          end
        endcase
      end
      i2cms_pkg::L_BIT: begin
        ln.qtr = lq.qtr + 2'h1;
        case (lq.qtr)
          i2cms_pkg::QTR_DATA: begin
            if (q.cmd == i2cms_pkg::CMD_WRITE) begin
              ln.sda_lo = (lq.bitn < i2cms_pkg::ACK_SLOT) && !lq.sh[7];
            end else begin
              ln.sda_lo = (lq.bitn == i2cms_pkg::ACK_SLOT) && q.ack_en;
            end
          end
          i2cms_pkg::QTR_RISE: ln.scl_lo = 1'b0;
          i2cms_pkg::QTR_SAMPLE: begin
            if (!lq.scl_s1) begin
              ln.qtr = lq.qtr;
            end else if (lq.bitn < i2cms_pkg::ACK_SLOT) begin
              ln.rx = {lq.rx[6:0], lq.sda_s1};
              ln.sh = {lq.sh[6:0], 1'b0};
            end else begin
              ln.ackd = !lq.sda_s1;
            end
          end
          default: begin
            ln.scl_lo = 1'b1;
            if (lq.bitn == i2cms_pkg::ACK_SLOT) begin
              // SDA is left as it is here: freeing it in the instant SCL falls could look like a stop.
              ln.done_tgl = ~lq.done_tgl;
              ln.st = i2cms_pkg::L_IDLE;
            end else begin
              ln.bitn = lq.bitn + 4'h1;
            end
          end
        endcase
      end
      default: begin
        ln.st = i2cms_pkg::L_IDLE;
      end
    endcase
    // Reset arrives through the two-stage synchroniser and clears only engine state.
    if (lq.rs1) begin
      ln.seen = 1'b0;
      ln.st = i2cms_pkg::L_IDLE;
      ln.qtr = 2'h0;
      ln.bitn = 4'h0;
      ln.sh = 8'h00;
      ln.rx = 8'h00;
      ln.ackd = 1'b0;
      ln.done_tgl = 1'b0;
      ln.scl_lo = 1'b0;
      ln.sda_lo = 1'b0;
    end
  end

  // Bit engine register; its reset is applied in the next-state logic above.
  always_ff @(posedge LINK_CLK) begin
    lq <= ln;
  end

  // Open-drain pins only ever pull low.
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = lq.scl_lo;
  assign SDA_OE = lq.sda_lo;
  assign DR_RDATA = q.dr;
  assign EVENT_FLAG = q.event_flag;
  assign START_SENT_FLAG = q.sb;
  assign BYTE_DONE_FLAG = q.byte_done_flag;
  assign MASTER_SELECT_FLAG = q.msl;
  assign BUS_BUSY_FLAG = q.busy;
  assign ADDR10_FLAG = q.addr10;
  assign ACK_FAIL_FLAG = q.ack_fail;
  assign PEC_VALUE = q.pec;
  assign IRQ = q.event_flag && INTERRUPT_ENABLE;

endmodule

`default_nettype wire

// >>> verif/i2cms_checker.sv
// Concurrent checks on the ports of the two-wire master sequencer.
`timescale 1ns/1ps
`default_nettype none
module i2cms_checker (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic INTERFACE_ENABLE,
  input wire logic START_REQ,
  input wire logic INTERRUPT_ENABLE,
  input wire logic DR_READ,
  input wire logic DR_WRITE,
  input wire logic CR_WRITE,
  input wire logic EVENT_FLAG,
  input wire logic START_SENT_FLAG,
  input wire logic BYTE_DONE_FLAG,
  input wire logic MASTER_SELECT_FLAG,
  input wire logic BUS_BUSY_FLAG,
  input wire logic IRQ,
  input wire logic SCL_OE,
  input wire logic SDA_OE
);
  // All checks run on the core clock and rest while reset is high.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_start_taken;
    $rose(START_REQ) && INTERFACE_ENABLE && !BUS_BUSY_FLAG && !MASTER_SELECT_FLAG
      |-> ##[1:3] MASTER_SELECT_FLAG;
  endproperty
  a_start_taken: assert property (p_start_taken) else $error("start not taken");
  property p_busy_wait;
    BUS_BUSY_FLAG && !MASTER_SELECT_FLAG |=> !MASTER_SELECT_FLAG;
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("master on busy bus");
  property p_sent;
    $rose(MASTER_SELECT_FLAG) |-> ##[1:400] START_SENT_FLAG && EVENT_FLAG;
  endproperty
  a_sent: assert property (p_sent) else $error("start sent flags missing");
  // Stretching must cover every pending event; SCL_OE is a link flop, so this also
  // catches an event that is raised before the clock line is actually held.
  property p_hold;
    EVENT_FLAG |-> SCL_OE;
  endproperty
  a_hold: assert property (p_hold) else $error("clock released with event");
  property p_clear;
    $fell(EVENT_FLAG) |-> $past(DR_WRITE) || $past(CR_WRITE) || $past(DR_READ);
  endproperty
  a_clear: assert property (p_clear) else $error("event cleared without access");
  property p_btf;
    $rose(BYTE_DONE_FLAG) |-> EVENT_FLAG && MASTER_SELECT_FLAG && !START_SENT_FLAG;
  endproperty
  a_btf: assert property (p_btf) else $error("byte done without event");
  property p_irq;
    IRQ == (EVENT_FLAG && INTERRUPT_ENABLE);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");
  property p_slave_idle;
    !MASTER_SELECT_FLAG |-> !SCL_OE && !SDA_OE;
  endproperty
  a_slave_idle: assert property (p_slave_idle) else $error("slave drives lines");
  property p_event_master;
    $rose(EVENT_FLAG) |-> MASTER_SELECT_FLAG;
  endproperty
  a_event_master: assert property (p_event_master) else $error("event in slave mode");
endmodule
bind i2cms_top i2cms_checker u_chk (.REF_CLK, .RST, .INTERFACE_ENABLE, .START_REQ,
  .INTERRUPT_ENABLE, .DR_READ, .DR_WRITE, .CR_WRITE, .EVENT_FLAG, .START_SENT_FLAG,
  .BYTE_DONE_FLAG, .MASTER_SELECT_FLAG, .BUS_BUSY_FLAG, .IRQ, .SCL_OE, .SDA_OE);
`default_nettype wire

// >>> verif/i2cms_slave.sv
// Behavioural two-wire slave that acknowledges writes and returns a counting byte pattern.
`timescale 1ns/1ps
`default_nettype none
module i2cms_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] sh = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic [15:0] acks = 16'h0000;
  int nwr = 0;
  int nrd = 0;
  wire logic [7:0] tx = 8'h5a + 8'h33 * 8'(nrd);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // A start or stop on the wire restarts the framing; only a start arms the address byte.
  always @(sda) if (scl) begin
    cnt = 4'h0;
    rd = 1'b0;
    first = !sda;
    nwr = 0;
    nrd = 0;
  end
  // Bits are taken on the rising clock; the ninth slot carries the acknowledge.
  always @(posedge scl) begin
    if (cnt < 4'h8) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
    end else begin
      cnt = 4'h0;
      if (rd) begin
        acks[nrd] = sda;
        nrd++;
        rd = !sda;
      end else begin
        last_wr = sh;
        nwr++;
        if (first) rd = sh[0];
      end
      first = 1'b0;
    end
  end
  // SDA moves only while SCL is low, so the master never sees a false start or stop.
  always @(negedge scl) begin
    if (cnt == 4'h8) sda_oe = !rd;
    else sda_oe = rd && !tx[3'(4'h7 - cnt)];
    if (slow) begin
      scl_oe = 1'b1;
      #250;
      scl_oe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/i2cms_tb_top.sv
// Self-checking bench for the two-wire master sequencer against a behavioural slave.
`timescale 1ns/1ps
`default_nettype none
module i2cms_tb_top;
  logic REF_CLK = 1'b0, LINK_CLK = 1'b0, RST = 1'b1, INTERFACE_ENABLE = 1'b1;
  logic START_REQ = 1'b0, STOP_REQ = 1'b0, ACK_ENABLE = 1'b1, INTERRUPT_ENABLE = 1'b1;
  logic SR1_READ = 1'b0, DR_READ = 1'b0, DR_WRITE = 1'b0, CR_WRITE = 1'b0;
  logic [7:0] DR_WDATA = 8'h00;
  logic [7:0] DR_RDATA, PEC_VALUE;
  logic EVENT_FLAG, START_SENT_FLAG, BYTE_DONE_FLAG, MASTER_SELECT_FLAG, BUS_BUSY_FLAG;
  logic ADDR10_FLAG, ACK_FAIL_FLAG, IRQ, SCL_OE, SDA_OE, s_scl_oe, s_sda_oe;
  logic tb_sda_oe = 1'b0, slow = 1'b0;
  logic [7:0] pec = 8'h00;
  int failures = 0, checks_done = 0;
  // Both lines are pulled up; any party may pull them low.
  wire logic scl_w = !(SCL_OE || s_scl_oe);
  wire logic sda_w = !(SDA_OE || s_sda_oe || tb_sda_oe);
  always #5 REF_CLK = !REF_CLK;
  always #80 LINK_CLK = !LINK_CLK;
  i2cms_top dut (.REF_CLK, .RST, .LINK_CLK, .INTERFACE_ENABLE, .START_REQ, .STOP_REQ,
    .ACK_ENABLE, .INTERRUPT_ENABLE, .SR1_READ, .DR_READ, .DR_WRITE, .CR_WRITE, .DR_WDATA,
    .DR_RDATA, .EVENT_FLAG, .START_SENT_FLAG, .BYTE_DONE_FLAG, .MASTER_SELECT_FLAG,
    .BUS_BUSY_FLAG, .ADDR10_FLAG, .ACK_FAIL_FLAG, .PEC_VALUE, .IRQ, .SCL_I(scl_w),
    .SCL_O(), .SCL_OE, .SDA_I(sda_w), .SDA_O(), .SDA_OE);
  i2cms_slave slv (.scl(scl_w), .sda(sda_w), .slow(slow), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
  // Compares count every check; an unknown never matches.
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  // One register access: 0 status read, 1 data write, 2 control write, 3 data read.
  task acc(input int k);
    @(negedge REF_CLK);
    SR1_READ = (k == 0);
    DR_WRITE = (k == 1);
    CR_WRITE = (k == 2);
    DR_READ = (k == 3);
    @(negedge REF_CLK);
    {SR1_READ, DR_WRITE, CR_WRITE, DR_READ} = 4'h0;
  endtask
  // Bounded wait on the event flag (sel 0) or the master flag (sel 1).
  task wait_lvl(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? EVENT_FLAG : MASTER_SELECT_FLAG) !== v && n < 3000) begin
      @(negedge REF_CLK);
      n++;
    end
    if (n == 3000) cmp_bit(!v, v);
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[7 - i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Start, address byte or bytes, then the control write that ends addressing.
  task address(input logic [7:0] a, input logic ten, input logic [7:0] a2);
    pec = crc(8'h00, a);
    wait_lvl(0, 1'b1);
    cmp_bit(START_SENT_FLAG, 1'b1);
    cmp_bit(MASTER_SELECT_FLAG, 1'b1);
    cmp_bit(IRQ, INTERRUPT_ENABLE);
    cmp_bit(scl_w, 1'b0);
    acc(0);
    DR_WDATA = a;
    acc(1);
    START_REQ = 1'b0;
    @(negedge REF_CLK);
    cmp_bit(EVENT_FLAG | START_SENT_FLAG, 1'b0);
    if (ten) begin
      wait_lvl(0, 1'b1);
      cmp_byte(8'(slv.nwr), 8'h01);
      cmp_bit(scl_w, 1'b0);
      acc(0);
      DR_WDATA = a2;
      acc(1);
      pec = crc(pec, a2);
    end
    wait_lvl(0, 1'b1);
    cmp_byte(8'(slv.nwr), ten ? 8'h02 : 8'h01);
    cmp_byte(slv.last_wr, ten ? a2 : a);
    cmp_bit(ACK_FAIL_FLAG | scl_w, 1'b0);
    acc(0);
    acc(2);
  endtask
  // Receive n bytes, nack the last one and stop; the stop bit may be pulsed instead of held.
  task read(input int n, input logic pulse);
    logic [7:0] e;
    for (int i = 0; i < n; i++) begin
      e = 8'h5a + 8'h33 * 8'(i);
      wait_lvl(0, 1'b1);
      cmp_bit(BYTE_DONE_FLAG, 1'b1);
      cmp_bit(scl_w, 1'b0);
      cmp_byte(DR_RDATA, e);
      pec = crc(pec, e);
      if (i == n - 2) ACK_ENABLE = 1'b0;
      if (i == n - 1) STOP_REQ = 1'b1;
      acc(0);
      if (i == n - 1 && pulse) STOP_REQ = 1'b0;
      acc(3);
    end
    wait_lvl(1, 1'b0);
    cmp_bit(MASTER_SELECT_FLAG, 1'b0);
    cmp_bit(scl_w & sda_w, 1'b1);
    cmp_byte(PEC_VALUE, pec);
    for (int i = 0; i < n; i++) cmp_bit(slv.acks[i], i == n - 1);
    STOP_REQ = 1'b0;
    ACK_ENABLE = 1'b1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset is held long enough for the link-side engine to see it as well.
  initial begin
    repeat (80) @(negedge REF_CLK);
    RST = 1'b0;
    repeat (70) @(negedge REF_CLK);
    cmp_bit(MASTER_SELECT_FLAG | SCL_OE | SDA_OE, 1'b0);
    tb_sda_oe = 1'b1;
    repeat (40) @(negedge REF_CLK);
    cmp_bit(BUS_BUSY_FLAG, 1'b1);
    START_REQ = 1'b1;
    repeat (100) @(negedge REF_CLK);
    cmp_bit(MASTER_SELECT_FLAG, 1'b0);
    tb_sda_oe = 1'b0;
    address(8'ha1, 1'b0, 8'h00);
    read(3, 1'b1);
    $display("test 1 done: busy wait and 7-bit read");
    INTERRUPT_ENABLE = 1'b0;
    START_REQ = 1'b1;
    address(8'hf2, 1'b1, 8'h5c);
    cmp_bit(ADDR10_FLAG & MASTER_SELECT_FLAG, 1'b1);
    slow = 1'b1;
    START_REQ = 1'b1;
    address(8'hf3, 1'b0, 8'h00);
    read(2, 1'b0);
    $display("test 2 done: 10-bit header, repeated start, slow read");
    wrap_up;
  end
  // Watchdog well beyond the expected run of about ten thousand core cycles.
  initial begin
    #400000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
